// *** src/bfdl_pkg.sv ***
// Constants, register map and mode type of the breaker failure decision logic
`default_nettype none
package bfdl_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 5; // 200 MHz reference clock
	localparam int TICK_TIME_NS = 1000000; // One millisecond time base
	localparam int TICK_CYCLES_DFLT = TICK_TIME_NS / CLK_PERIOD_NS;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00; // Mode and retrip enable
	localparam logic [7:0] OFS_PH_THR = 8'h04; // Phase threshold, percent
	localparam logic [7:0] OFS_RES_THR = 8'h08; // Residual threshold, percent
	localparam logic [7:0] OFS_RT_DLY = 8'h0C; // Retrip delay, ms
	localparam logic [7:0] OFS_BU_DLY = 8'h10; // Backup delay, ms
	localparam logic [7:0] OFS_PULSE = 8'h14; // Trip pulse duration, ms
	localparam logic [7:0] OFS_STATUS = 8'h18; // Live state, read only
	// ==========================================================
	// Control field positions
	localparam int CTRL_MODE_LSB = 0; // Two-bit supervision mode
	localparam int CTRL_RETRIP_BIT = 2; // Retrip enable
	// ==========================================================
	// Setting ranges and reset values
	localparam logic [15:0] PH_THR_MIN = 16'h0014; // 20 %
	localparam logic [15:0] PH_THR_MAX = 16'h00C8; // 200 %
	localparam logic [15:0] PH_THR_RST = 16'h001E; // 30 %
	localparam logic [15:0] RES_THR_MIN = 16'h000A; // 10 %
	localparam logic [15:0] RES_THR_MAX = 16'h00C8; // 200 %
	localparam logic [15:0] RES_THR_RST = 16'h0014; // 20 %
	localparam logic [15:0] RT_DLY_MIN = 16'h0000; // 0 ms
	localparam logic [15:0] RT_DLY_MAX = 16'h03E8; // 1000 ms
	localparam logic [15:0] RT_DLY_RST = 16'h0064; // 100 ms
	localparam logic [15:0] BU_DLY_MIN = 16'h0064; // 100 ms
	localparam logic [15:0] BU_DLY_MAX = 16'hEA60; // 60000 ms
	localparam logic [15:0] BU_DLY_RST = 16'h03E8; // 1000 ms
	localparam logic [15:0] PULSE_MIN = 16'h0000; // 0 ms
	localparam logic [15:0] PULSE_MAX = 16'hEA60; // 60000 ms
	localparam logic [15:0] PULSE_RST = 16'h0064; // 100 ms
	localparam logic [15:0] CNT_SAT = 16'hFFFF; // Millisecond counter ceiling
	// ==========================================================
	// Supervision modes, off is the reset value
	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_CURRENT,
		MODE_CONTACT,
		MODE_BOTH
	} bfdl_mode_e;
endpackage
`default_nettype wire

// *** src/bfdl_top.sv ***
// Breaker failure decision logic with its Avalon-MM settings registers
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`default_nettype none
// What this block does
// [R1] Combine starts, status and settings into trip
// [R2] Mode: off, current, contact, both; reset off
// [R3] Mode picks current, contact or both supervised
// [R4] Retrip enable gates retrips, default off
// [R5] Phase threshold 20..200 percent, default 30
// [R6] Residual threshold 10..200 percent, default 20
// [R7] Retrip delay 0..1000 ms, default 100
// [R8] Backup delay 100..60000 ms, default 1000
// [R9] Pulse duration 0..60000 ms, default 100
// [R10] Block input suppresses every trip output
// [R11] Outside logic drives breaker closed inputs
// [R12] Outside logic drives general and phase starts
// [R13] Outside logic drives residual start input
// [R14] Per-phase flag while current above threshold
// [R15] Residual flag while residual above threshold
// [R16] Backup trip output plus three retrip outputs
// [R17] Comparisons use sampled current values
// [R18] Start rising edge starts per-phase timers
// [R19] Backup trip at expiry if fault persists
// [R20] Trip held at least the pulse duration
// [R21] Retrip at retrip expiry where fault persists
// [R22] Clear when start and fault drop, blocked, off
module bfdl_top
	import bfdl_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output var logic [31:0] avs_readdata,
	output var logic avs_waitrequest,
	input wire logic block_in,
	input wire logic breaker_closed_common,
	input wire logic breaker_closed_phase1,
	input wire logic breaker_closed_phase2,
	input wire logic breaker_closed_phase3,
	input wire logic general_initiate,
	input wire logic initiate_phase1,
	input wire logic initiate_phase2,
	input wire logic initiate_phase3,
	input wire logic initiate_residual,
	input wire logic [15:0] phase1_current,
	input wire logic [15:0] phase2_current,
	input wire logic [15:0] phase3_current,
	input wire logic [15:0] residual_current,
	output var logic backup_trip_out,
	output var logic retrip_phase1,
	output var logic retrip_phase2,
	output var logic retrip_phase3
);
	// ==========================================================
	// Settings and bus state
	bfdl_mode_e mode_reg; // Supervision mode
	logic retrip_en_reg; // Retrip enable
	logic [15:0] ph_thr_reg; // Phase threshold, percent
	logic [15:0] res_thr_reg; // Residual threshold, percent
	logic [15:0] rt_dly_reg; // Retrip delay, ms
	logic [15:0] bu_dly_reg; // Backup delay, ms
	logic [15:0] pulse_dur_reg; // Trip pulse length, ms
	logic wait_reg; // Drives waitrequest
	logic [31:0] rdata_reg; // Drives readdata
	logic [31:0] wr_word; // Write data merged with old value
	logic [31:0] old_word; // Current value at the write address
	logic wr_take; // Write accepted this edge
	// ==========================================================
	// Decision state; index 0..2 phases, 3 residual channel
	logic [31:0] tick_cnt_reg; // Millisecond prescaler
	logic ms_tick; // One-cycle millisecond pulse
	logic [3:0] over_reg; // Over-threshold flags
	logic [3:0] start_prev_reg; // Start levels one cycle back
	logic gen_prev_reg; // General start one cycle back
	logic [3:0] start_lvl; // Start levels per channel
	logic [3:0] start_rise; // Start rising edges per channel
	logic [3:0] closed; // Contact view per channel
	logic [3:0] cond; // Supervised fault condition
	logic [3:0] active_reg; // Channel timing
	logic [15:0] bu_cnt_reg [4]; // Backup timers, ms
	logic [15:0] rt_cnt_reg [3]; // Retrip timers, ms
	logic [3:0] bu_hit; // Backup timer expired with fault
	logic [2:0] rt_hit; // Retrip timer expired with fault
	logic inhibit; // Blocked or switched off
	logic [15:0] cur [4]; // Sampled current per channel
	logic bu_trip_reg; // Backup trip
	logic [15:0] bu_pulse_reg; // Backup pulse age, ms
	logic [2:0] rt_reg; // Retrips
	logic [15:0] rt_pulse_reg [3]; // Retrip pulse age, ms

	// Byte-lane merge of write data over an old register value
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = n[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Clamp a setting into its legal range
	function automatic logic [15:0] clamp(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// ==========================================================
	// Avalon-MM slave: every access answers one cycle after request
	assign wr_take = avs_write && !wait_reg;
	assign wr_word = merge(old_word, avs_writedata, avs_byteenable);

	// Old value of the addressed register for partial writes
	always_comb begin
		old_word = 32'h0000_0000;
		unique case (avs_address)
			OFS_CTRL: begin
				old_word[CTRL_MODE_LSB +: 2] = mode_reg;
				old_word[CTRL_RETRIP_BIT] = retrip_en_reg;
			end
			OFS_PH_THR: old_word[15:0] = ph_thr_reg;
			OFS_RES_THR: old_word[15:0] = res_thr_reg;
			OFS_RT_DLY: old_word[15:0] = rt_dly_reg;
			OFS_BU_DLY: old_word[15:0] = bu_dly_reg;
			OFS_PULSE: old_word[15:0] = pulse_dur_reg;
			OFS_STATUS: begin
				old_word[0] = bu_trip_reg;
				old_word[3:1] = rt_reg;
				old_word[7:4] = over_reg;
				old_word[11:8] = active_reg;
			end
			default: old_word = 32'h0000_0000;
		endcase
	end

	// Waitrequest drops for exactly one cycle per request
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wait_reg <= 1'b1;
		end else if ((avs_read || avs_write) && wait_reg) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= 1'b1;
		end
	end

	// Read data captured as waitrequest drops; unmapped reads zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (avs_read && wait_reg) begin
			rdata_reg <= old_word;
		end
	end

	// Settings, clamped into range on write; unmapped writes dropped
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode_reg <= MODE_OFF; // [R2]
			retrip_en_reg <= 1'b0; // [R4]
			ph_thr_reg <= PH_THR_RST; // [R5]
			res_thr_reg <= RES_THR_RST; // [R6]
			rt_dly_reg <= RT_DLY_RST; // [R7]
			bu_dly_reg <= BU_DLY_RST; // [R8]
			pulse_dur_reg <= PULSE_RST; // [R9]
		end else if (wr_take) begin
			unique case (avs_address)
				OFS_CTRL: begin
					mode_reg <= bfdl_mode_e'(wr_word[CTRL_MODE_LSB +: 2]);
					retrip_en_reg <= wr_word[CTRL_RETRIP_BIT];
				end
				OFS_PH_THR: ph_thr_reg <= clamp(wr_word[15:0],
					PH_THR_MIN, PH_THR_MAX); // [R5]
				OFS_RES_THR: res_thr_reg <= clamp(wr_word[15:0],
					RES_THR_MIN, RES_THR_MAX); // [R6]
				OFS_RT_DLY: rt_dly_reg <= clamp(wr_word[15:0],
					RT_DLY_MIN, RT_DLY_MAX); // [R7]
				OFS_BU_DLY: bu_dly_reg <= clamp(wr_word[15:0],
					BU_DLY_MIN, BU_DLY_MAX); // [R8]
				OFS_PULSE: pulse_dur_reg <= clamp(wr_word[15:0],
					PULSE_MIN, PULSE_MAX); // [R9]
				default: mode_reg <= mode_reg;
			endcase
		end
	end

	// ==========================================================
	// Millisecond time base
	assign ms_tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

	always_ff @(posedge ref_clk) begin
		if (!rst_n || ms_tick) begin
			tick_cnt_reg <= 32'h0000_0000;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
		end
	end

	// ==========================================================
	// Channel inputs
	assign inhibit = block_in || (mode_reg == MODE_OFF); // [R10] [R22]
	assign cur[0] = phase1_current;
	assign cur[1] = phase2_current;
	assign cur[2] = phase3_current;
	assign cur[3] = residual_current;
	assign start_lvl = {initiate_residual, initiate_phase3,
		initiate_phase2, initiate_phase1};
	assign closed = {breaker_closed_common | breaker_closed_phase1 |
		breaker_closed_phase2 | breaker_closed_phase3,
		breaker_closed_common | breaker_closed_phase3,
		breaker_closed_common | breaker_closed_phase2,
		breaker_closed_common | breaker_closed_phase1};
	// Phase channels also start on a general start edge [R18]
	assign start_rise[2:0] = (start_lvl[2:0] & ~start_prev_reg[2:0]) |
		{3{general_initiate && !gen_prev_reg}};
	assign start_rise[3] = start_lvl[3] && !start_prev_reg[3];

	// Edge history of the start inputs
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			start_prev_reg <= 4'h0;
			gen_prev_reg <= 1'b0;
		end else begin
			start_prev_reg <= start_lvl;
			gen_prev_reg <= general_initiate;
		end
	end

	// Threshold comparisons on the sampled currents
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			over_reg <= 4'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				over_reg[i] <= cur[i] > ph_thr_reg; // [R14] [R17]
			end
			over_reg[3] <= cur[3] > res_thr_reg; // [R15] [R17]
		end
	end

	// Supervised condition chosen by the mode
	always_comb begin
		unique case (mode_reg)
			MODE_OFF: cond = 4'h0;
			MODE_CURRENT: cond = over_reg; // [R3]
			MODE_CONTACT: cond = closed; // [R3]
			// Fault persists until every faultless condition holds
			MODE_BOTH: cond = over_reg | closed; // [R3] [R21]
		endcase
	end

	// ==========================================================
	// Per-channel timers
	for (genvar c = 0; c < 4; c++) begin : g_chan
		// Activity and backup timer of one channel
		always_ff @(posedge ref_clk) begin
			if (!rst_n || inhibit) begin
				active_reg[c] <= 1'b0; // [R10] [R22]
				bu_cnt_reg[c] <= 16'h0000;
			end else if (start_rise[c]) begin
				active_reg[c] <= 1'b1; // [R18]
				bu_cnt_reg[c] <= 16'h0000;
			end else if (active_reg[c] && !start_lvl[c] &&
				!(c < 3 && general_initiate) && !cond[c]) begin
				active_reg[c] <= 1'b0; // [R22]
				bu_cnt_reg[c] <= 16'h0000;
			end else if (active_reg[c] && ms_tick &&
				bu_cnt_reg[c] != CNT_SAT) begin
				bu_cnt_reg[c] <= bu_cnt_reg[c] + 16'h0001;
			end
		end
		assign bu_hit[c] = active_reg[c] && cond[c] &&
			(bu_cnt_reg[c] >= bu_dly_reg); // [R19]
	end

	for (genvar p = 0; p < 3; p++) begin : g_phase
		// Separate retrip timer of one phase
		always_ff @(posedge ref_clk) begin
			if (!rst_n || !active_reg[p] || start_rise[p]) begin
				rt_cnt_reg[p] <= 16'h0000; // [R18]
			end else if (ms_tick && rt_cnt_reg[p] != CNT_SAT) begin
				rt_cnt_reg[p] <= rt_cnt_reg[p] + 16'h0001;
			end
		end
		assign rt_hit[p] = active_reg[p] && cond[p] &&
			(rt_cnt_reg[p] >= rt_dly_reg); // [R21]

		// Retrip output with minimum pulse length
		always_ff @(posedge ref_clk) begin
			if (!rst_n || inhibit || !retrip_en_reg) begin
				rt_reg[p] <= 1'b0; // [R4] [R10]
				rt_pulse_reg[p] <= 16'h0000;
			end else if (rt_hit[p]) begin
				rt_reg[p] <= 1'b1; // [R21]
				rt_pulse_reg[p] <= 16'h0000;
			end else if (rt_reg[p] && rt_pulse_reg[p] >= pulse_dur_reg) begin
				rt_reg[p] <= 1'b0; // [R20]
			end else if (rt_reg[p] && ms_tick &&
				rt_pulse_reg[p] != CNT_SAT) begin
				rt_pulse_reg[p] <= rt_pulse_reg[p] + 16'h0001;
			end
		end
	end

	// ==========================================================
	// Backup trip with minimum pulse length
	always_ff @(posedge ref_clk) begin
		if (!rst_n || inhibit) begin
			bu_trip_reg <= 1'b0; // [R10]
			bu_pulse_reg <= 16'h0000;
		end else if (|bu_hit) begin
			bu_trip_reg <= 1'b1; // [R1] [R19]
			bu_pulse_reg <= 16'h0000;
		end else if (bu_trip_reg && bu_pulse_reg >= pulse_dur_reg) begin
			bu_trip_reg <= 1'b0; // [R20] [R22]
		end else if (bu_trip_reg && ms_tick && bu_pulse_reg != CNT_SAT) begin
			bu_pulse_reg <= bu_pulse_reg + 16'h0001;
		end
	end

	// Outputs straight from flip-flops [R16]
	assign backup_trip_out = bu_trip_reg;
	assign retrip_phase1 = rt_reg[0];
	assign retrip_phase2 = rt_reg[1];
	assign retrip_phase3 = rt_reg[2];
	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_block_kills_trip: assert property (block_in |=> // [R10]
		!backup_trip_out && !retrip_phase1 && !retrip_phase2 &&
		!retrip_phase3) else $error("trip while blocked");
	a_off_mode_idle: assert property (mode_reg == MODE_OFF |=> // [R2]
		active_reg == 4'h0) else $error("timer runs while off");
	a_rise_starts: assert property (!inhibit && start_rise[0] |=> // [R18]
		active_reg[0] && bu_cnt_reg[0] == 16'h0000 &&
		rt_cnt_reg[0] == 16'h0000) else $error("start edge missed");
	a_backup_expiry: assert property (!inhibit && (|bu_hit) |=> // [R19]
		backup_trip_out) else $error("backup trip not raised");
	a_trip_has_cause: assert property ($rose(backup_trip_out) |-> // [R1]
		$past(|bu_hit)) else $error("backup trip without expiry");
	a_pulse_minimum: assert property ($fell(backup_trip_out) && // [R20]
		!$past(inhibit) |-> $past(bu_pulse_reg) >= $past(pulse_dur_reg))
		else $error("trip pulse too short");
	a_retrip_gated: assert property (!retrip_en_reg |=> // [R4]
		!retrip_phase1 && !retrip_phase2 && !retrip_phase3)
		else $error("retrip while disabled");
	a_retrip_expiry: assert property (!inhibit && retrip_en_reg && // [R21]
		rt_hit[1] |=> retrip_phase2) else $error("retrip not raised");
	a_phase_flag: assert property (1'b1 |=> over_reg[0] == // [R14]
		($past(phase1_current) > $past(ph_thr_reg)))
		else $error("phase flag wrong");
	a_residual_flag: assert property (1'b1 |=> over_reg[3] == // [R15]
		($past(residual_current) > $past(res_thr_reg)))
		else $error("residual flag wrong");
	a_quiet_clears: assert property (active_reg[3] && !cond[3] && // [R22]
		!start_lvl[3] |=> !active_reg[3]) else $error("channel stuck");
	a_bus_answer: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");

	c_backup_trip: cover property ($rose(backup_trip_out));
	c_retrip: cover property ($rose(retrip_phase1));
	c_block_in_trip: cover property (backup_trip_out && block_in);
endmodule
`default_nettype wire

// *** tb/bfdl_far_model.sv ***
// Far-side model: upstream trip logic and breaker auxiliary contacts
`default_nettype none
module bfdl_far_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [4:0] want_start,
	input wire logic [3:0] want_closed,
	input wire logic load_closed,
	input wire logic [7:0] open_lag,
	input wire logic trip_seen,
	output var logic [4:0] start_reg,
	output var logic [3:0] closed_reg
);
	// ==========================================================
	// State
	logic [7:0] lag_reg; // Cycles of trip seen since contacts loaded

	// Starts follow the requests one edge later, as clocked logic would
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			start_reg <= 5'h00;
		end else begin
			start_reg <= want_start;
		end
	end

	// Contacts open a set lag after a trip, so answers may be slow
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			closed_reg <= 4'h0;
			lag_reg <= 8'h00;
		end else if (load_closed) begin
			closed_reg <= want_closed;
			lag_reg <= 8'h00;
		end else if (trip_seen) begin
			lag_reg <= lag_reg + 8'h01;
			// Breaker finally opens all poles
			if (lag_reg == open_lag) begin
				closed_reg <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/bfdl_top_bench.sv ***
// Self-checking bench for the breaker failure decision logic
`default_nettype none
module bfdl_top_bench
	import bfdl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Settings tables, index 6 is an unmapped address
	localparam int T = 10; // Cycles per millisecond tick here
	localparam logic [7:0] ADR [0:6] = '{OFS_CTRL, OFS_PH_THR,
		OFS_RES_THR, OFS_RT_DLY, OFS_BU_DLY, OFS_PULSE, 8'h1C};
	localparam logic [15:0] RST [0:6] = '{16'h0000, PH_THR_RST,
		RES_THR_RST, RT_DLY_RST, BU_DLY_RST, PULSE_RST, 16'h0000};
	localparam logic [15:0] LO [0:6] = '{16'h0000, PH_THR_MIN,
		RES_THR_MIN, RT_DLY_MIN, BU_DLY_MIN, PULSE_MIN, 16'h0000};
	localparam logic [15:0] HI [0:6] = '{16'h0000, PH_THR_MAX,
		RES_THR_MAX, RT_DLY_MAX, BU_DLY_MAX, PULSE_MAX, 16'h0000};
	// ==========================================================
	// Signals
	logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address, open_lag;
	logic [31:0] avs_writedata, avs_readdata, rd, lfsr_reg;
	logic [3:0] avs_byteenable, want_closed, closed_w, outs;
	logic block_in, load_closed;
	logic [15:0] cur1, cur2, cur3, cur_res;
	logic [4:0] want_start, start_w; // General, phase 1..3, residual
	logic backup_trip_out, retrip_phase1, retrip_phase2, retrip_phase3;
	int fails, check_count;
	assign outs = {retrip_phase3, retrip_phase2, retrip_phase1,
		backup_trip_out};
	// ==========================================================
	// Instances
	bfdl_top #(.TICK_CYCLES(T)) bfdl_top_inst (.ref_clk(ref_clk),
		.rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .block_in(block_in),
		.breaker_closed_common(closed_w[0]),
		.breaker_closed_phase1(closed_w[1]),
		.breaker_closed_phase2(closed_w[2]),
		.breaker_closed_phase3(closed_w[3]),
		.general_initiate(start_w[0]), .initiate_phase1(start_w[1]),
		.initiate_phase2(start_w[2]), .initiate_phase3(start_w[3]),
		.initiate_residual(start_w[4]), .phase1_current(cur1),
		.phase2_current(cur2), .phase3_current(cur3),
		.residual_current(cur_res), .backup_trip_out(backup_trip_out),
		.retrip_phase1(retrip_phase1), .retrip_phase2(retrip_phase2),
		.retrip_phase3(retrip_phase3));
	bfdl_far_model bfdl_far_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.want_start(want_start), .want_closed(want_closed),
		.load_closed(load_closed), .open_lag(open_lag),
		.trip_seen(|outs), .start_reg(start_w), .closed_reg(closed_w));
	// ==========================================================
	// Clock and watchdog
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (30000) @(posedge ref_clk);
		fails++;
		final_report();
	end
	// ==========================================================
	// Expectation functions
	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
	endfunction
	function automatic logic [15:0] clamp(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
	// Flags for threshold 30 on phases and 20 on residual
	function automatic logic [3:0] flags(input logic [15:0] a,
		input logic [15:0] b, input logic [15:0] c, input logic [15:0] r);
		return {r > 16'h0014, c > 16'h001E, b > 16'h001E, a > 16'h001E};
	endfunction
	// ==========================================================
	// Tasks
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) fails++;
	endtask
	// Control word, default thresholds, backup 100 ms
	task automatic cfg(input logic [2:0] ctl, input logic [15:0] rt,
		input logic [15:0] pul);
		bus(1'b1, OFS_CTRL, {29'h0, ctl});
		bus(1'b1, OFS_PH_THR, 32'h0000001E);
		bus(1'b1, OFS_RES_THR, 32'h00000014);
		bus(1'b1, OFS_RT_DLY, {16'h0, rt});
		bus(1'b1, OFS_BU_DLY, 32'h00000064);
		bus(1'b1, OFS_PULSE, {16'h0, pul});
	endtask
	task automatic watch(input int n, output logic [3:0] seen);
		seen = 4'h0;
		repeat (n) begin
			@(posedge ref_clk);
			seen = seen | outs;
		end
	endtask
	// Start, time the trip, drop the fault, time the pulse
	task automatic fire(input logic [4:0] st, input logic [3:0] eo,
		input int lo, input int hi, input int pul);
		int n;
		n = 0;
		want_start <= st;
		while ((outs & eo) === 4'h0 && n < hi + 5) begin
			@(posedge ref_clk);
			n++;
		end
		check("rise time", 32'(n >= lo && n <= hi), 32'h1);
		check("outputs at rise", {28'h0, outs}, {28'h0, eo});
		want_start <= 5'h00;
		cur1 <= 16'h0000;
		cur_res <= 16'h0000;
		n = 0;
		while ((outs & eo) !== 4'h0 && n < (pul + 1) * T + 20) begin
			@(posedge ref_clk);
			n++;
		end
		check("hold time", 32'(n >= (pul - 1) * T &&
			n <= (pul + 1) * T + 15), 32'h1);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		int i;
		int k;
		logic [15:0] v;
		logic [3:0] seen;
		rst_n = 1'b0;
		{avs_read, avs_write, block_in, load_closed} = 4'h0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		{cur1, cur2, cur3, cur_res} = 64'h0;
		want_start = 5'h00;
		want_closed = 4'h0;
		open_lag = 8'hFF;
		lfsr_reg = 32'h98DF;
		fails = 0;
		check_count = 0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		// Reset values and an unmapped read
		for (i = 0; i < 7; i++) begin
			bus(1'b0, ADR[i], 32'h0);
			check("reset value", rd, {16'h0, RST[i]});
		end
		// Low, high and random settings read back clamped
		for (i = 0; i < 15; i++) begin
			k = 1 + i % 5;
			lfsr_reg = lfsr_step(lfsr_reg);
			v = (i < 5) ? 16'h0000 : ((i < 10) ? 16'hFFFF : lfsr_reg[15:0]);
			bus(1'b1, ADR[k], {16'h0, v});
			bus(1'b0, ADR[k], 32'h0);
			check("setting", rd, {16'h0, clamp(v, LO[k], HI[k])});
		end
		bus(1'b1, OFS_STATUS, 32'h0000FFFF);
		bus(1'b0, OFS_STATUS, 32'h0);
		check("status write ignored", rd, 32'h0);
		// Over-threshold flags, boundary values first
		cfg(3'h1, 16'h0064, 16'h0005);
		for (i = 0; i < 8; i++) begin
			lfsr_reg = lfsr_step(lfsr_reg);
			cur1 <= (i == 0) ? 16'h001E : {8'h00, lfsr_reg[7:0]};
			cur2 <= (i == 0) ? 16'h001F : {8'h00, lfsr_reg[15:8]};
			cur3 <= {8'h00, lfsr_reg[23:16]};
			cur_res <= (i == 0) ? 16'h0015 : {8'h00, lfsr_reg[31:24]};
			repeat (3) @(posedge ref_clk);
			bus(1'b0, OFS_STATUS, 32'h0);
			check("flags", {28'h0, rd[7:4]},
				{28'h0, flags(cur1, cur2, cur3, cur_res)});
		end
		{cur1, cur2, cur3, cur_res} <= 64'h0;
		// Mode off never trips
		cfg(3'h0, 16'h0064, 16'h0005);
		cur1 <= 16'h0032;
		want_start <= 5'h02;
		watch(1200, seen);
		check("off mode", {28'h0, seen}, 32'h0);
		want_start <= 5'h00;
		// Current mode backup trip, retrip disabled
		cfg(3'h1, 16'h0064, 16'h0005);
		fire(5'h02, 4'h1, 99 * T, 100 * T + 5, 5);
		// Residual start in combined mode
		cfg(3'h3, 16'h0064, 16'h0003);
		cur_res <= 16'h0032;
		fire(5'h10, 4'h1, 99 * T, 100 * T + 5, 3);
		// Contact mode retrip in phase 2, breaker opens late
		want_closed <= 4'h4;
		load_closed <= 1'b1;
		open_lag <= 8'h08;
		@(posedge ref_clk);
		load_closed <= 1'b0;
		cfg(3'h6, 16'h0003, 16'h0004);
		fire(5'h04, 4'h4, 2 * T, 3 * T + 5, 4);
		watch(1100, seen);
		check("no backup after open", {28'h0, seen}, 32'h0);
		// Block mid-timing, then release without a new start edge
		cfg(3'h1, 16'h0064, 16'h0005);
		cur2 <= 16'h0032;
		want_start <= 5'h01;
		repeat (300) @(posedge ref_clk);
		block_in <= 1'b1;
		watch(1000, seen);
		check("blocked", {28'h0, seen}, 32'h0);
		block_in <= 1'b0;
		watch(1200, seen);
		check("after unblock", {28'h0, seen}, 32'h0);
		want_start <= 5'h00;
		final_report();
	end
endmodule
`default_nettype wire
